/* design/gmc_guest_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module gmc_guest_ctl
    import gmc_pkg::*;
#(
    parameter bit         HAS_IDCTL   = 1'b1,
    parameter bit         HAS_CTL_EXT = 1'b0,
    parameter bit         HAS_IRQCTL  = 1'b0,
    parameter bit         HAS_PT      = 1'b1,
    parameter bit         HAS_CG      = 1'b1,
    parameter bit         HAS_DRG     = 1'b1,
    parameter bit         HAS_CU2_CHANGE_TRAP_MASK    = 1'b0,
    parameter bit         HAS_IMPL    = 1'b0,
    parameter bit         RAD_MODE    = 1'b0,
    parameter bit         AT_WRITABLE = 1'b1,
    parameter logic [1:0] AT_RESET    = 2'h3
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        root_mode_in,
    input  wire logic        reg_wr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic        exception_level_flag_in,
    input  wire logic        debug_mode_flag_in,
    input  wire logic        root_kernel_in,
    input  wire logic        root_erl_in,
    input  wire logic [7:0]  root_guest_id_in,
    input  wire logic        guest_kernel_in,
    input  wire logic        ri_exc_in,
    input  wire logic        psi_op_in,
    input  wire logic        psi_selectable_in,
    input  wire logic        indexed_tlb_write_in,
    input  wire logic        timer_read_in,
    input  wire logic        compare_access_in,
    input  wire logic        cycle_counter_read_in,
    input  wire logic        cache_op_in,
    input  wire logic        cache_addr_type_in,
    input  wire logic        config_write_in,
    input  wire logic        priv_level_change_in,
    input  wire logic        guest_exl_change_in,
    input  wire logic        cu1_change_in,
    input  wire logic        cu2_change_in,
    input  wire logic        hypercall_in,
    input  wire logic        root_tlb_gva_in,
    input  wire logic        root_tlb_gpa_in,
    input  wire logic [5:0]  ext_irq_in,
    input  wire logic        unmapped_root_access_in,
    output logic             guest_mode_out,
    output logic             root_trap_out,
    output logic             guest_ri_out,
    output logic [5:0]       guest_irq_pending_out,
    output logic             root_data_via_tlb_out,
    output logic             addr_error_out
);
    typedef struct packed {
        logic       gm;
        logic       ri;
        logic       mc;
        logic       cp0;
        logic [1:0] at;
        logic       gt;
        logic       cg;
        logic       cf;
        logic [1:0] impl;
        logic [5:0] irq_passthrough_mask;
        logic       direct_guest_access_root;
        logic [4:0] cause;
        logic       cu2_change_trap_mask;
        logic       cu1_change_trap_mask;
    } gmc_state_t;

    gmc_state_t st_reg;
    gmc_state_t st_next;
    logic       guest;
    logic       psi_trap;
    gmc_event_t ev;

    assign guest = st_reg.gm && !exception_level_flag_in
                   && !debug_mode_flag_in; // RL1

    always_comb begin
        psi_trap = 1'b0;
        if (guest && guest_kernel_in) begin
            if (psi_op_in && (!st_reg.cp0 || !psi_selectable_in))
                psi_trap = 1'b1; // RL4
            if (indexed_tlb_write_in
                && (!st_reg.cp0 || st_reg.at != AT_GUEST))
                psi_trap = 1'b1; // RL4
            if (!st_reg.gt && (timer_read_in || compare_access_in))
                psi_trap = 1'b1; // RL6
            if (config_write_in && !st_reg.cf)
                psi_trap = 1'b1; // RL8
        end
        if (guest && cycle_counter_read_in && !st_reg.gt)
            psi_trap = 1'b1; // RL6
        if (guest && cache_op_in && !(st_reg.cg && cache_addr_type_in))
            psi_trap = 1'b1; // RL7
    end

    // Priority fixes which cause wins when events coincide
    always_comb begin
        ev = GMC_EV_NONE;
        if (root_tlb_gpa_in)
            ev = GMC_EV_GPA;
        else if (root_tlb_gva_in)
            ev = GMC_EV_GVA;
        else if (guest && ri_exc_in && st_reg.ri)
            ev = GMC_EV_GRR; // RL2
        else if (psi_trap)
            ev = GMC_EV_PSI;
        else if (guest && hypercall_in)
            ev = GMC_EV_HC;
        else if (guest && guest_exl_change_in)
            ev = GMC_EV_HFC; // RL3
        else if (guest && ((priv_level_change_in && st_reg.mc)
                 || (cu1_change_in && !st_reg.cu1_change_trap_mask)
                 || (cu2_change_in && !st_reg.cu2_change_trap_mask)))
            ev = GMC_EV_SFC; // RL3 RL17 RL18
    end

    function automatic logic [4:0] ev_code(input gmc_event_t e);
        case (e)
            GMC_EV_PSI: ev_code = EXC_PSI; // RL19
            GMC_EV_SFC: ev_code = EXC_SFC;
            GMC_EV_HC:  ev_code = EXC_HC;
            GMC_EV_GRR: ev_code = EXC_GRR;
            GMC_EV_GVA: ev_code = EXC_GVA;
            GMC_EV_HFC: ev_code = EXC_HFC;
            GMC_EV_GPA: ev_code = EXC_GPA;
            default:    ev_code = EXC_PSI;
        endcase
    endfunction

    always_comb begin
        st_next = st_reg;
        if (reg_wr_in && root_mode_in) begin // RL20
            st_next.gm  = reg_wdata_in[GM_BIT];
            st_next.ri  = reg_wdata_in[RI_BIT];
            st_next.mc  = reg_wdata_in[MC_BIT];
            st_next.cp0 = reg_wdata_in[CP0_BIT];
            // Only legal owner encodings are accepted
            if (AT_WRITABLE && (reg_wdata_in[AT_HI:AT_LO] == AT_ROOT
                || reg_wdata_in[AT_HI:AT_LO] == AT_GUEST))
                st_next.at = reg_wdata_in[AT_HI:AT_LO]; // RL5
            st_next.gt  = reg_wdata_in[GT_BIT];
            st_next.cg  = HAS_CG & reg_wdata_in[CG_BIT]; // RL7
            st_next.cf  = reg_wdata_in[CF_BIT];
            st_next.impl = HAS_IMPL ? reg_wdata_in[IMP_HI:IMP_LO]
                                    : 2'h0; // RL10
            st_next.irq_passthrough_mask = HAS_PT ? reg_wdata_in[PIP_HI:PIP_LO]
                                 : 6'h00; // RL11
            st_next.direct_guest_access_root = HAS_DRG & reg_wdata_in[DRG_BIT]; // RL15
            st_next.cu2_change_trap_mask = HAS_CU2_CHANGE_TRAP_MASK & reg_wdata_in[CU2_CHANGE_TRAP_MASK_BIT]; // RL17
            st_next.cu1_change_trap_mask = reg_wdata_in[CU1_CHANGE_TRAP_MASK_BIT];
        end
        // Cause is loaded only by hardware capture; a software write leaves it unchanged
        if (ev != GMC_EV_NONE)
            st_next.cause = ev_code(ev); // RL16
        if (!rst_n_in) begin
            st_next = '0;
            st_next.at = AT_RESET;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        st_reg <= st_next;
    end

    always_comb begin
        reg_rdata_out = 32'h0000_0000;
        reg_rdata_out[GM_BIT]  = st_reg.gm;
        reg_rdata_out[RI_BIT]  = st_reg.ri;
        reg_rdata_out[MC_BIT]  = st_reg.mc;
        reg_rdata_out[CP0_BIT] = st_reg.cp0;
        reg_rdata_out[AT_HI:AT_LO] = st_reg.at;
        reg_rdata_out[GT_BIT]  = st_reg.gt;
        reg_rdata_out[CG_BIT]  = st_reg.cg;
        reg_rdata_out[CF_BIT]  = st_reg.cf;
        reg_rdata_out[G1_BIT]  = HAS_IDCTL; // RL9
        reg_rdata_out[IMP_HI:IMP_LO] = st_reg.impl;
        reg_rdata_out[G0E_BIT] = HAS_CTL_EXT;
        reg_rdata_out[PT_BIT]  = HAS_PT; // RL11
        reg_rdata_out[PIP_HI:PIP_LO] = st_reg.irq_passthrough_mask;
        reg_rdata_out[RAD_BIT] = RAD_MODE; // RL13
        reg_rdata_out[DRG_BIT] = st_reg.direct_guest_access_root;
        reg_rdata_out[G2_BIT]  = HAS_IRQCTL;
        reg_rdata_out[GEX_HI:GEX_LO] = st_reg.cause;
        reg_rdata_out[CU2_CHANGE_TRAP_MASK_BIT] = st_reg.cu2_change_trap_mask;
        reg_rdata_out[CU1_CHANGE_TRAP_MASK_BIT] = st_reg.cu1_change_trap_mask;
        if (!root_mode_in)
            reg_rdata_out = 32'h0000_0000; // RL20
    end

    assign guest_mode_out = guest;
    assign root_trap_out  = (ev != GMC_EV_NONE);
    assign guest_ri_out   = guest && ri_exc_in && !st_reg.ri; // RL2
    assign guest_irq_pending_out = ext_irq_in & st_reg.irq_passthrough_mask; // RL12
    assign root_data_via_tlb_out = st_reg.direct_guest_access_root && !guest
        && (root_guest_id_in != 8'h00) && root_kernel_in
        && !exception_level_flag_in && !root_erl_in
        && !debug_mode_flag_in; // RL14
    assign addr_error_out = root_data_via_tlb_out
        && unmapped_root_access_in; // RL15

    // Mode gating
    a_guest_mode_gate: assert property (@(posedge clk_sys_in) // RL1
        disable iff (!rst_n_in)
        guest_mode_out |-> st_reg.gm && !exception_level_flag_in)
        else $error("guest mode while gated off");
    a_exl_blocks_guest: assert property (@(posedge clk_sys_in) // RL1
        disable iff (!rst_n_in)
        exception_level_flag_in |-> !guest_mode_out)
        else $error("guest mode during exception level");
    a_debug_blocks_guest: assert property (@(posedge clk_sys_in) // RL1
        disable iff (!rst_n_in)
        debug_mode_flag_in |-> !guest_mode_out)
        else $error("guest mode during debug");

    // Reserved-instruction redirect
    a_redirect_cause: assert property (@(posedge clk_sys_in) // RL2
        disable iff (!rst_n_in)
        (guest && ri_exc_in && st_reg.ri && !root_tlb_gpa_in
         && !root_tlb_gva_in) |=> st_reg.cause == EXC_GRR)
        else $error("redirect cause not recorded");
    a_ri_stays_guest: assert property (@(posedge clk_sys_in) // RL2
        disable iff (!rst_n_in)
        (guest && ri_exc_in && !st_reg.ri) |-> guest_ri_out)
        else $error("reserved instruction not kept in guest");
    a_ri_no_local: assert property (@(posedge clk_sys_in) // RL2
        disable iff (!rst_n_in)
        st_reg.ri |-> !guest_ri_out)
        else $error("redirected exception also taken in guest");

    // Field change events
    a_hfc_cause: assert property (@(posedge clk_sys_in) // RL3
        disable iff (!rst_n_in)
        (ev == GMC_EV_HFC) |=> st_reg.cause == 5'h09)
        else $error("hardware field change code wrong");
    a_sfc_cause: assert property (@(posedge clk_sys_in) // RL3
        disable iff (!rst_n_in)
        (ev == GMC_EV_SFC) |=> st_reg.cause == 5'h01)
        else $error("software field change code wrong");
    a_cu1_trap: assert property (@(posedge clk_sys_in) // RL18
        disable iff (!rst_n_in)
        (guest && cu1_change_in && !st_reg.cu1_change_trap_mask) |-> root_trap_out)
        else $error("coprocessor 1 change not trapped");
    a_cu2_change_trap_mask_absent: assert property (@(posedge clk_sys_in) // RL17
        disable iff (!rst_n_in)
        !HAS_CU2_CHANGE_TRAP_MASK |-> !st_reg.cu2_change_trap_mask)
        else $error("absent coprocessor 2 mask set");

    // Privileged-sensitive traps
    a_psi_cp0_clear: assert property (@(posedge clk_sys_in) // RL4
        disable iff (!rst_n_in)
        (guest && guest_kernel_in && psi_op_in && !st_reg.cp0)
        |-> psi_trap)
        else $error("privileged op not trapped");
    a_indexed_tlb_write_trap: assert property (@(posedge clk_sys_in) // RL4
        disable iff (!rst_n_in)
        (guest && guest_kernel_in && indexed_tlb_write_in
         && st_reg.at != AT_GUEST) |-> psi_trap)
        else $error("indexed write not trapped");
    a_timer_trap: assert property (@(posedge clk_sys_in) // RL6
        disable iff (!rst_n_in)
        (guest && guest_kernel_in && !st_reg.gt && compare_access_in)
        |-> root_trap_out)
        else $error("timer access not trapped");
    a_cycle_trap: assert property (@(posedge clk_sys_in) // RL6
        disable iff (!rst_n_in)
        (guest && cycle_counter_read_in && !st_reg.gt) |-> psi_trap)
        else $error("cycle counter read not trapped");
    a_cache_trap: assert property (@(posedge clk_sys_in) // RL7
        disable iff (!rst_n_in)
        (guest && cache_op_in && !st_reg.cg) |-> psi_trap)
        else $error("cache op not trapped");
    a_cache_operand: assert property (@(posedge clk_sys_in) // RL7
        disable iff (!rst_n_in)
        (guest && cache_op_in && !cache_addr_type_in) |-> psi_trap)
        else $error("cache operand type not trapped");
    a_cache_absent: assert property (@(posedge clk_sys_in) // RL7
        disable iff (!rst_n_in)
        !HAS_CG |-> !st_reg.cg)
        else $error("absent cache enable set");
    a_config_trap: assert property (@(posedge clk_sys_in) // RL8
        disable iff (!rst_n_in)
        (guest && guest_kernel_in && config_write_in && !st_reg.cf)
        |-> psi_trap)
        else $error("config write not trapped");

    // Register image
    a_owner_legal: assert property (@(posedge clk_sys_in) // RL5
        disable iff (!rst_n_in)
        (st_reg.at == AT_ROOT) || (st_reg.at == AT_GUEST))
        else $error("owner field holds reserved code");
    a_owner_fixed: assert property (@(posedge clk_sys_in) // RL5
        disable iff (!rst_n_in)
        !AT_WRITABLE |-> st_reg.at == AT_RESET)
        else $error("fixed owner field changed");
    a_presence_flags: assert property (@(posedge clk_sys_in) // RL9
        disable iff (!rst_n_in)
        root_mode_in |-> reg_rdata_out[G1_BIT] == HAS_IDCTL
        && reg_rdata_out[G0E_BIT] == HAS_CTL_EXT
        && reg_rdata_out[G2_BIT] == HAS_IRQCTL)
        else $error("presence flag wrong");
    a_impl_absent: assert property (@(posedge clk_sys_in) // RL10
        disable iff (!rst_n_in)
        !HAS_IMPL |-> st_reg.impl == 2'h0)
        else $error("absent implementation bits set");
    a_dealias_bit: assert property (@(posedge clk_sys_in) // RL13
        disable iff (!rst_n_in)
        root_mode_in |-> reg_rdata_out[RAD_BIT] == RAD_MODE)
        else $error("dealias mode bit wrong");
    a_cause_hold: assert property (@(posedge clk_sys_in) // RL16
        disable iff (!rst_n_in)
        (ev == GMC_EV_NONE) |=> $stable(st_reg.cause))
        else $error("cause changed without event");
    a_gpa_cause: assert property (@(posedge clk_sys_in) // RL19
        disable iff (!rst_n_in)
        root_tlb_gpa_in |=> st_reg.cause == 5'h0a)
        else $error("physical address fault code wrong");

    // Interrupt pass-through
    a_pip_mask: assert property (@(posedge clk_sys_in) // RL12
        disable iff (!rst_n_in)
        (st_reg.irq_passthrough_mask == 6'h00) |-> guest_irq_pending_out == 6'h00)
        else $error("masked interrupt visible");
    a_pt_absent: assert property (@(posedge clk_sys_in) // RL11
        disable iff (!rst_n_in)
        !HAS_PT |-> guest_irq_pending_out == 6'h00)
        else $error("pass-through without capability");

    // Direct root access to guest entries
    a_direct_guest: assert property (@(posedge clk_sys_in) // RL14
        disable iff (!rst_n_in)
        root_data_via_tlb_out |-> st_reg.direct_guest_access_root && root_kernel_in
        && (root_guest_id_in != 8'h00))
        else $error("direct access without its conditions");
    a_direct_gated: assert property (@(posedge clk_sys_in) // RL14
        disable iff (!rst_n_in)
        guest_mode_out |-> !root_data_via_tlb_out)
        else $error("direct access in guest mode");
    a_drg_absent: assert property (@(posedge clk_sys_in) // RL15
        disable iff (!rst_n_in)
        !HAS_DRG |-> !st_reg.direct_guest_access_root)
        else $error("absent direct access bit set");
    a_addr_error: assert property (@(posedge clk_sys_in) // RL15
        disable iff (!rst_n_in)
        addr_error_out |-> root_data_via_tlb_out && unmapped_root_access_in)
        else $error("address error without unmapped access");

    // Root-only reach
    a_hidden_read: assert property (@(posedge clk_sys_in) // RL20
        disable iff (!rst_n_in)
        !root_mode_in |-> reg_rdata_out == 32'h0000_0000)
        else $error("register visible outside root");
    a_write_root_only: assert property (@(posedge clk_sys_in) // RL20
        disable iff (!rst_n_in)
        (reg_wr_in && !root_mode_in) |=> $stable(st_reg.gm))
        else $error("guest write changed control");
endmodule
`default_nettype wire

/* design/gmc_pkg.sv */
// How it works
// [RL1] Guest mode runs only with mode flag set, no exception level, no debug.
// [RL2] Redirect bit sends guest reserved-instruction traps to root.
// [RL3] Mode-change enable gates privilege-level trap; exception-level change always traps.
// [RL4] Privileged op bit clear traps all; set allows some, indexed write needs owner 3.
// [RL5] Two-bit MMU owner field: 1 root control, 3 guest control, 0 reserved.
// [RL6] Timer bit gates guest count, compare and cycle-counter access.
// [RL7] Cache bit clear traps cache ops; set allows only address operand type.
// [RL8] Config bit gates guest-kernel writes to configuration registers 0..7.
// [RL9] Read-only presence flags for id, extension and interrupt registers.
// [RL10] Implementation bits ignore writes and read zero when absent.
// [RL11] Pass-through capability flag; when zero mask field is reserved.
// [RL12] Pass-through mask bits expose external interrupts as guest pending 7:2.
// [RL13] Read-only dealias mode bit selects dealias scheme.
// [RL14] Direct-guest bit with nonzero root id maps root kernel data via root TLB.
// [RL15] Direct-guest bit reads zero when unsupported; unmapped root access faults.
// [RL16] Read-only cause code records why guest trap went to root.
// [RL17] Coprocessor-2 usable change traps unless mask set; reads zero if absent.
// [RL18] Coprocessor-1 usable change traps unless mask set.
// [RL19] Cause codes 0,1,2,3,8,10 and 9 as listed.
// [RL20] Register reachable only in root mode, one copy per virtual element.
package gmc_pkg;
    localparam int GM_BIT   = 31;
    localparam int RI_BIT   = 30;
    localparam int MC_BIT   = 29;
    localparam int CP0_BIT  = 28;
    localparam int AT_HI    = 27;
    localparam int AT_LO    = 26;
    localparam int GT_BIT   = 25;
    localparam int CG_BIT   = 24;
    localparam int CF_BIT   = 23;
    localparam int G1_BIT   = 22;
    localparam int IMP_HI   = 21;
    localparam int IMP_LO   = 20;
    localparam int G0E_BIT  = 19;
    localparam int PT_BIT   = 18;
    localparam int PIP_HI   = 15;
    localparam int PIP_LO   = 10;
    localparam int RAD_BIT  = 9;
    localparam int DRG_BIT  = 8;
    localparam int G2_BIT   = 7;
    localparam int GEX_HI   = 6;
    localparam int GEX_LO   = 2;
    localparam int CU2_CHANGE_TRAP_MASK_BIT = 1;
    localparam int CU1_CHANGE_TRAP_MASK_BIT = 0;
    localparam logic [1:0] AT_ROOT  = 2'h1;
    localparam logic [1:0] AT_GUEST = 2'h3;
    localparam logic [4:0] EXC_PSI  = 5'h00;
    localparam logic [4:0] EXC_SFC  = 5'h01;
    localparam logic [4:0] EXC_HC   = 5'h02;
    localparam logic [4:0] EXC_GRR  = 5'h03;
    localparam logic [4:0] EXC_GVA  = 5'h08;
    localparam logic [4:0] EXC_HFC  = 5'h09;
    localparam logic [4:0] EXC_GPA  = 5'h0a;
    typedef enum logic [2:0] {
        GMC_EV_PSI, GMC_EV_SFC, GMC_EV_HC, GMC_EV_GRR,
        GMC_EV_GVA, GMC_EV_HFC, GMC_EV_GPA, GMC_EV_NONE
    } gmc_event_t;
endpackage

/* bench/tb_guest_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_guest_mode_control import gmc_pkg::*;;
    localparam int E_RI = 0, E_PSI = 1, E_SEL = 2, E_TLBW = 3, E_TMR = 4;
    localparam int E_CMP = 5, E_CYC = 6, E_CACHE = 7, E_CADDR = 8, E_CFG = 9;
    localparam int E_PRIV = 10, E_EXL = 11, E_CU1 = 12, E_CU2 = 13, E_HC = 14;
    localparam int E_GVA = 15, E_GPA = 16;
    // Guest mode flag set, owner field at its guest-control value
    localparam logic [31:0] GB = 32'h8c000000;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        root_mode_in = 1'b1;
    logic        reg_wr_in = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [16:0] evs = '0;
    logic        exception_level_flag = 1'b0, dm = 1'b0, rk = 1'b0, erl = 1'b0, gk = 1'b1;
    logic        unm = 1'b0;
    logic [7:0]  root_guest_id = 8'h00;
    logic [5:0]  irq = 6'h00, pend;
    logic        gm_o, trap_o, ri_o, via_o, aerr_o;
    int          error_cnt = 0, n_tests = 0, cyc = 0;

    gmc_guest_ctl DUT (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .root_mode_in(root_mode_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .exception_level_flag_in(exception_level_flag), .debug_mode_flag_in(dm),
        .root_kernel_in(rk), .root_erl_in(erl), .root_guest_id_in(root_guest_id),
        .guest_kernel_in(gk), .ri_exc_in(evs[0]), .psi_op_in(evs[1]),
        .psi_selectable_in(evs[2]), .indexed_tlb_write_in(evs[3]),
        .timer_read_in(evs[4]), .compare_access_in(evs[5]),
        .cycle_counter_read_in(evs[6]), .cache_op_in(evs[7]),
        .cache_addr_type_in(evs[8]), .config_write_in(evs[9]),
        .priv_level_change_in(evs[10]), .guest_exl_change_in(evs[11]),
        .cu1_change_in(evs[12]), .cu2_change_in(evs[13]),
        .hypercall_in(evs[14]), .root_tlb_gva_in(evs[15]),
        .root_tlb_gpa_in(evs[16]), .ext_irq_in(irq),
        .unmapped_root_access_in(unm), .guest_mode_out(gm_o),
        .root_trap_out(trap_o), .guest_ri_out(ri_o),
        .guest_irq_pending_out(pend), .root_data_via_tlb_out(via_o),
        .addr_error_out(aerr_o)
    );

    always #25 clk_sys_in = ~clk_sys_in;

    function automatic logic [16:0] eb(input int n);
        return 17'h1 << n;
    endfunction
    function automatic logic [31:0] fb(input int n);
        return 32'h1 << n;
    endfunction

    task automatic tick;
        @(posedge clk_sys_in);
        #2;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [31:0] v);
        reg_wr_in = 1'b1;
        wdata = v;
        tick();
        reg_wr_in = 1'b0;
    endtask

    task automatic ev(input logic [31:0] ctl, input logic [16:0] e,
                      input logic trap, input logic [4:0] code);
        wr(ctl);
        evs = e;
        #1 chk("root trap", {31'h0, trap}, trap_o);
        tick();
        evs = '0;
        if (trap) chk("cause", {25'h0, code, 2'h0}, rdata & 32'h7c);
    endtask

    task automatic t_access;
        chk("reset image", 32'h0c440000, rdata);
        wr(32'hffffffff);
        chk("write ones", 32'hffc4fd01, rdata);
        root_mode_in = 1'b0;
        #1 chk("hidden read", 32'h0, rdata);
        wr(32'h0);
        root_mode_in = 1'b1;
        #1 chk("root only write", 32'hffc4fd01, rdata);
        wr(32'h0);
        chk("owner zero refused", 32'h0c440000, rdata);
        wr(32'h04000000);
        chk("owner root", 32'h04440000, rdata);
        wr(32'h08000000);
        chk("owner two refused", 32'h04440000, rdata);
        $display("test access done");
    endtask

    task automatic t_mode;
        for (int i = 0; i < 8; i++) begin
            wr(i[0] ? GB : 32'h0c000000);
            exception_level_flag = i[1];
            dm = i[2];
            #1 chk("guest mode", {31'h0, i[0] & ~i[1] & ~i[2]}, gm_o);
        end
        exception_level_flag = 1'b0;
        dm = 1'b0;
        $display("test mode done");
    endtask

    task automatic t_traps;
        logic [16:0] sel;
        sel = eb(E_PSI) | eb(E_SEL);
        ev(GB, eb(E_PSI), 1'b1, EXC_PSI);
        ev(GB | fb(CP0_BIT), sel, 1'b0, 5'h00);
        ev(GB | fb(CP0_BIT), sel | eb(E_TLBW), 1'b0, 5'h00);
        ev(32'h84000000 | fb(CP0_BIT), sel | eb(E_TLBW), 1'b1, EXC_PSI);
        ev(32'h0c000000, eb(E_PSI) | eb(E_HC), 1'b0, 5'h00);
        ev(GB, eb(E_TMR), 1'b1, EXC_PSI);
        ev(GB | fb(GT_BIT), eb(E_TMR) | eb(E_CMP) | eb(E_CYC), 1'b0, 5'h00);
        ev(GB, eb(E_CACHE) | eb(E_CADDR), 1'b1, EXC_PSI);
        ev(GB | fb(CG_BIT), eb(E_CACHE) | eb(E_CADDR), 1'b0, 5'h00);
        ev(GB | fb(CG_BIT), eb(E_CACHE), 1'b1, EXC_PSI);
        ev(GB, eb(E_CFG), 1'b1, EXC_PSI);
        ev(GB | fb(CF_BIT), eb(E_CFG), 1'b0, 5'h00);
        ev(GB, eb(E_PRIV), 1'b0, 5'h00);
        ev(GB | fb(MC_BIT), eb(E_PRIV), 1'b1, EXC_SFC);
        ev(GB, eb(E_EXL), 1'b1, EXC_HFC);
        ev(GB, eb(E_CU1), 1'b1, EXC_SFC);
        ev(GB | fb(CU1_CHANGE_TRAP_MASK_BIT), eb(E_CU1), 1'b0, 5'h00);
        ev(GB | fb(CU2_CHANGE_TRAP_MASK_BIT), eb(E_CU2), 1'b1, EXC_SFC);
        ev(GB, eb(E_HC), 1'b1, EXC_HC);
        ev(GB, eb(E_GVA), 1'b1, EXC_GVA);
        ev(GB, eb(E_GPA) | eb(E_HC) | eb(E_PRIV), 1'b1, EXC_GPA);
        ev(GB | fb(RI_BIT), eb(E_RI), 1'b1, EXC_GRR);
        ev(GB | fb(RI_BIT), eb(E_GVA) | eb(E_RI), 1'b1, EXC_GVA);
        wr(GB);
        evs = eb(E_RI);
        #1 chk("guest ri", 32'h1, {31'h0, ri_o});
        tick();
        evs = '0;
        $display("test traps done");
    endtask

    task automatic t_irq_drg;
        wr(GB | 32'h0000a800);
        irq = 6'h3f;
        #1 chk("irq pending", 32'h2a, {26'h0, pend});
        irq = 6'h0f;
        #1 chk("irq pending", 32'h0a, {26'h0, pend});
        wr(32'h0c000000 | fb(DRG_BIT));
        root_guest_id = 8'h05;
        rk = 1'b1;
        #1 chk("via tlb", 32'h1, {31'h0, via_o});
        erl = 1'b1;
        #1 chk("via tlb", 32'h0, {31'h0, via_o});
        erl = 1'b0;
        root_guest_id = 8'h00;
        #1 chk("via tlb", 32'h0, {31'h0, via_o});
        root_guest_id = 8'h05;
        unm = 1'b1;
        #1 chk("addr error", 32'h1, {31'h0, aerr_o});
        wr(32'h0c000000);
        #1 chk("addr error", 32'h0, {31'h0, aerr_o});
        unm = 1'b0;
        rk = 1'b0;
        $display("test irq and direct access done");
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Run needs under a hundred cycles; generous ceiling catches a hang
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        repeat (20) @(posedge clk_sys_in);
        #2;
        rst_n_in = 1'b1;
        tick();
        t_access();
        t_mode();
        t_traps();
        t_irq_drg();
        summarize();
    end
endmodule
`default_nettype wire
